// ==== verif/rtc_alarm_watchdog_sqw_sva.sv ====
`timescale 1ns/100ps
// ==========================================================
// Port checker
module rtc_alarm_watchdog_sqw_sva (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  // Register port
  input  wire logic       wr_strobe_in,
  input  wire logic       rd_strobe_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] addr_ptr_in,
  input  wire logic [7:0] rdata_out,
  // Time and outputs
  input  wire logic       time_tick_in,
  input  wire logic       shared_interrupt_pin_out,
  input  wire logic       alarm_match_flag_out,
  input  wire logic       watchdog_timeout_flag_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // Cycles since the last watchdog write; the shortest timeout is far above 4000 cycles
  logic [11:0] wd_age_q;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wd_age_q <= 12'h000;
    end else if (wr_strobe_in && addr_in == 8'h09) begin
      wd_age_q <= 12'h000;
    end else if (wd_age_q != 12'hfff) begin
      wd_age_q <= wd_age_q + 12'h001;
    end
  end

  read_hold_a: assert property (!rd_strobe_in |=> $stable(rdata_out))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (rd_strobe_in && addr_in == 8'h10 |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  flag_clear_a: assert property (rd_strobe_in && addr_in == 8'h0f && !time_tick_in &&
    addr_ptr_in == $past(addr_ptr_in) |-> ##2 !alarm_match_flag_out)
    else $error("alarm flag survived a flag read");
  ptr_defer_a: assert property ($rose(alarm_match_flag_out) |-> $past(addr_ptr_in, 2) != 8'h0f)
    else $error("alarm flag set while pointer on flags");
  alarm_cause_a: assert property ($rose(alarm_match_flag_out) |->
    $past(time_tick_in, 2) || $past(addr_ptr_in, 2) != $past(addr_ptr_in, 3))
    else $error("alarm flag set without a time update");
  alarm_hold_a: assert property ($fell(alarm_match_flag_out) |->
    $past(rd_strobe_in, 2) && $past(addr_in, 2) == 8'h0f)
    else $error("alarm flag dropped without a flag read");
  wdf_hold_a: assert property ($fell(watchdog_timeout_flag_out) |->
    $past(rd_strobe_in, 2) && $past(addr_in, 2) == 8'h0f)
    else $error("watchdog flag dropped without a flag read");
  wd_restart_a: assert property ($rose(watchdog_timeout_flag_out) |-> wd_age_q > 12'hfa0)
    else $error("watchdog expired too soon after a write");
  open_drain_a: assert property (shared_interrupt_pin_out == 1'b0)
    else $error("shared pin data not low");
endmodule

bind rtc_alarm_watchdog_sqw rtc_alarm_watchdog_sqw_sva u_sva (
  .core_clk_in, .reset_in, .wr_strobe_in, .rd_strobe_in, .addr_in, .addr_ptr_in, .rdata_out,
  .time_tick_in, .shared_interrupt_pin_out, .alarm_match_flag_out, .watchdog_timeout_flag_out);

// ==== verif/rtc_alarm_watchdog_sqw_tb.sv ====
`timescale 1ns/100ps
module rtc_alarm_watchdog_sqw_tb;
  import rtc_alarm_pkg::*;
  logic core_clk_in = 1'b0, reset_in = 1'b1, osc_32k_in = 1'b0, time_tick_in = 1'b0;
  logic century_roll_in = 1'b0, backup_mode_in = 1'b0, wr_strobe_in, rd_strobe_in;
  logic [7:0] addr_in, addr_ptr_in, rdata_out;
  reg_byte_t wdata_in;
  logic [4:0] month_in = 5'h01;
  logic [5:0] date_in = 6'h01, hour_in = 6'h01;
  logic [6:0] minute_in = 7'h01, second_in = 7'h00;
  logic shared_interrupt_pin_out, oe_n, alarm_match_flag_out, watchdog_timeout_flag_out;
  logic [4:0] rpt;
  int n_fail = 0, n_checks = 0, cyc = 0, t0, n;

  rtc_alarm_watchdog_sqw u_dut (.core_clk_in, .reset_in, .osc_32k_in, .wr_strobe_in, .rd_strobe_in,
    .addr_in, .wdata_in, .addr_ptr_in, .rdata_out, .time_tick_in, .month_in, .date_in, .hour_in,
    .minute_in, .second_in, .century_roll_in, .backup_mode_in, .shared_interrupt_pin_out,
    .shared_interrupt_pin_oe_n_out(oe_n), .alarm_match_flag_out, .watchdog_timeout_flag_out);
  rtc_host_model u_host (.core_clk_in, .wr_strobe_out(wr_strobe_in), .rd_strobe_out(rd_strobe_in),
    .addr_out(addr_in), .wdata_out(wdata_in), .addr_ptr_out(addr_ptr_in), .rdata_in(rdata_out));

  always #5 core_clk_in = ~core_clk_in;
  // Oscillator runs at 8 clock periods so that long counts fit the run; figures are in its edges
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    #1 if (cyc % 4 == 0) osc_32k_in = ~osc_32k_in;
  end

  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask

  task automatic rng(input string s, input int lo, input int hi, input int v);
    n_checks++;
    if (v < lo || v > hi) begin
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, v);
      n_fail++;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
    logic [7:0] v;
    u_host.read_reg(a, v);
    chk(s, e, v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask

  task automatic edges(input int cycles, output int cnt);
    logic last;
    cnt = 0;
    last = oe_n;
    repeat (cycles) begin
      @(posedge core_clk_in);
      #1;
      cnt += (oe_n !== last);
      last = oe_n;
    end
  endtask

  // Fields: 0 second, 1 minute, 2 hour, 3 date, 4 month; a set bit makes that field miss
  task automatic alarm_tick(input logic [4:0] mis);
    second_in = mis[0] ? 7'h02 : 7'h01;
    minute_in = mis[1] ? 7'h02 : 7'h01;
    hour_in = mis[2] ? 6'h02 : 6'h01;
    date_in = mis[3] ? 6'h02 : 6'h01;
    month_in = mis[4] ? 5'h02 : 5'h01;
    @(posedge core_clk_in);
    #1 time_tick_in = 1'b1;
    @(posedge core_clk_in);
    #1 time_tick_in = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask

  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    rd(8'h09, 8'h00, "watchdog reset");
    rd(8'h08, 8'h80, "control reset");
    rd(8'h0a, 8'h00, "alarm month reset");
    rd(8'h0c, 8'h40, "alarm hour reset");
    rd(8'h01, 8'h80, "stop reset");
    rd(8'h10, 8'h00, "reserved");
    chk("pin idle", 8'h01, {7'h00, oe_n});
    wr(8'h08, 8'h00);
    chk("pin level low", 8'h00, {7'h00, oe_n});
    wr(8'h08, 8'hc0);
    edges(1100, n);
    rng("test output while stopped", 0, 0, n);
    wr(8'h01, 8'h00);
    edges(2048, n);
    rng("test output toggles", 7, 9, n);
    wr(8'h0a, 8'h40);
    for (int c = 1; c < 8; c++) begin
      wr(8'h13, 8'(c << 4));
      edges(2048, n);
      rng("square toggles", (c == 1 ? 512 : 2048 >> (c + 2)) - 1, (c == 1 ? 512 : 2048 >> (c + 2)) + 1, n);
    end
    wr(8'h13, 8'h00);
    edges(200, n);
    rng("square off", 0, 0, n + 32'(oe_n !== 1'b1));
    wr(8'h0a, 8'h00);
    // Watchdog: multiplier 1, resolution 1/16 s, i.e. 2048 oscillator edges
    u_host.write_reg(8'h09, 8'h84);
    rd(8'h09, 8'h04, "watchdog readback");
    edges(1000, n);
    rng("test output under watchdog", 0, 0, n + 32'(oe_n !== 1'b1));
    repeat (12000) @(posedge core_clk_in);
    u_host.write_reg(8'h09, 8'h04);
    t0 = cyc;
    while (oe_n !== 1'b0 && cyc - t0 < 20000) begin
      @(posedge core_clk_in);
      #1;
    end
    rng("watchdog period", 16376, 16400, cyc - t0);
    #1 chk("watchdog flag out", 8'h01, {7'h00, watchdog_timeout_flag_out});
    rd(8'h0f, 8'h80, "flags after timeout");
    rd(8'h0f, 8'h00, "flags cleared");
    chk("pin held after read", 8'h00, {7'h00, oe_n});
    // Test output off so the released pin is not hidden by its toggling
    wr(8'h08, 8'h80);
    wr(8'h09, 8'h00);
    chk("pin released", 8'h01, {7'h00, oe_n});
    wr(8'h08, 8'hc0);
    edges(2048, n);
    rng("watchdog stays off", 7, 9, n);
    wr(8'h08, 8'h80);
    wr(8'h0a, 8'h81);
    for (int m = 0; m < 6; m++) begin
      rpt = 5'h1f << m;
      wr(8'h0e, {rpt[0], 7'h01});
      wr(8'h0d, {rpt[1], 7'h01});
      wr(8'h0c, {rpt[2], 7'h01});
      wr(8'h0b, {rpt[3], rpt[4], 6'h01});
      for (int j = 0; j < 6; j++) begin
        alarm_tick(j < 5 ? 5'(1 << j) : 5'h00);
        rd(8'h0f, {1'b0, j >= m, 6'h00}, "repeat match");
      end
    end
    wr(8'h0d, 8'h81);
    wr(8'h0b, 8'h81);
    alarm_tick(5'h1f);
    chk("alarm pin", 8'h00, {7'h00, oe_n});
    rd(8'h0f, 8'h40, "odd repeat code");
    wr(8'h13, 8'h00);
    chk("alarm pin released", 8'h01, {7'h00, oe_n});
    rd(8'h0f, 8'h00, "alarm flag cleared");
    u_host.set_ptr(8'h0f);
    alarm_tick(5'h1f);
    chk("deferred flag", 8'h00, {7'h00, alarm_match_flag_out});
    u_host.set_ptr(8'h00);
    repeat (3) @(posedge core_clk_in);
    #1 chk("flag after pointer moves", 8'h01, {7'h00, alarm_match_flag_out});
    rd(8'h0f, 8'h40, "deferred flags");
    backup_mode_in = 1'b1;
    alarm_tick(5'h1f);
    chk("backup pin off", 8'h01, {7'h00, oe_n});
    rd(8'h0f, 8'h40, "backup flag");
    wr(8'h0a, 8'ha1);
    alarm_tick(5'h1f);
    chk("backup pin on", 8'h00, {7'h00, oe_n});
    rd(8'h0f, 8'h40, "backup flags");
    backup_mode_in = 1'b0;
    wr(8'h0a, 8'hc1);
    alarm_tick(5'h1f);
    chk("square blocks alarm", 8'h01, {7'h00, oe_n});
    rd(8'h0f, 8'h40, "square flags");
    hour_in = 6'h01;
    wr(8'h03, 8'h80);
    century_roll_in = 1'b1;
    @(posedge core_clk_in);
    #1 century_roll_in = 1'b0;
    rd(8'h03, 8'hc1, "century toggled");
    wr(8'h03, 8'h40);
    century_roll_in = 1'b1;
    @(posedge core_clk_in);
    #1 century_roll_in = 1'b0;
    rd(8'h03, 8'h41, "century kept");
    print_verdict();
  end
endmodule

// ==== verif/rtc_host_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Host side of the register port
module rtc_host_model (
  // Clock
  input  wire logic       core_clk_in,
  // Register port toward the block
  output logic            wr_strobe_out,
  output logic            rd_strobe_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic [7:0]      addr_ptr_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    wr_strobe_out = 1'b0;
    rd_strobe_out = 1'b0;
    addr_out      = 8'h00;
    wdata_out     = 8'h00;
    addr_ptr_out  = 8'h00;
  end

  // Every write, 00h after a timeout included, goes straight to the register
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    wr_strobe_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge core_clk_in);
    #1;
    wr_strobe_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    rd_strobe_out = 1'b1;
    addr_out = a;
    @(posedge core_clk_in);
    #1;
    rd_strobe_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask

  // Pointer is parked only on request, so a deferred alarm can be provoked at will
  task automatic set_ptr(input logic [7:0] p);
    @(posedge core_clk_in);
    #1;
    addr_ptr_out = p;
  endtask
endmodule

// ==== verilog/rtc_alarm_pkg.sv ====
package rtc_alarm_pkg;

  typedef enum logic [2:0] {
    RPT_SECOND,
    RPT_MINUTE,
    RPT_HOUR,
    RPT_DAY,
    RPT_MONTH,
    RPT_YEAR
  } repeat_mode_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// ==== verilog/rtc_alarm_regs.svh ====
`ifndef RTC_ALARM_REGS_SVH
`define RTC_ALARM_REGS_SVH

// ==========================================================
// Register offsets
`define OFS_SECONDS        8'h01
`define OFS_CENTURY_HOURS  8'h03
`define OFS_CONTROL        8'h08
`define OFS_WATCHDOG       8'h09
`define OFS_ALARM_MONTH    8'h0A
`define OFS_ALARM_DATE     8'h0B
`define OFS_ALARM_HOUR     8'h0C
`define OFS_ALARM_MINUTE   8'h0D
`define OFS_ALARM_SECOND   8'h0E
`define OFS_FLAGS          8'h0F
`define OFS_SQUARE_RATE    8'h13

// ==========================================================
// Field positions
`define BIT_STOP           7
`define BIT_CENTURY_EN     7
`define BIT_CENTURY        6
`define BIT_LEVEL          7
`define BIT_FREQ_TEST      6
`define BIT_PIN_ENABLE     7
`define BIT_SQUARE_ENABLE  6
`define BIT_BACKUP_ENABLE  5
`define BIT_RPT_HI         7
`define BIT_RPT5           6
`define BIT_HALT           6
`define BIT_WD_FLAG        7
`define BIT_ALARM_FLAG     6

// ==========================================================
// Reset values
`define RST_WATCHDOG       8'h00
`define RST_CONTROL        8'h80
`define RST_ALARM_MONTH    8'h00
`define RST_ALARM_HOUR     8'h40
`define RST_SQUARE_RATE    8'h00

// ==========================================================
// Timing, in oscillator edges
`define OSC_HZ             32768
`define WD_STEPS_PER_SEC   16
`define WD_STEP_TICKS      (`OSC_HZ / `WD_STEPS_PER_SEC)
`define FT_DIV_BIT         5

`endif

// ==== verilog/rtc_alarm_watchdog_sqw.sv ====
`timescale 1ns/100ps
`include "rtc_alarm_regs.svh"

// Function
// - Alarm month, date, hour, minute, second and repeat bits live at 0Ah-0Eh.
// - Repeat code picks second, minute, hour, day, month or year match.
// - Undefined repeat codes behave as once per second.
// - A time match under the repeat mode sets the alarm match flag.
// - Match with pin enable set and square enable clear pulls the pin.
// - Pointer parked on flag address defers the alarm until it moves.
// - Flag read releases alarm pin; cleared flag seen on next read.
// - In backup, alarm pulls pin only with backup and pin enables set.
// - Watchdog register: five-bit multiplier above two-bit resolution code.
// - Timeout is multiplier times resolution; expiry sets flag and, with square enable clear, pulls pin.
// - Every watchdog register write restarts the timeout period.
// - Writing 00h after timeout releases pin; watchdog stays off until reprogrammed.
// - Flag register read clears the watchdog timeout flag.
// - Power-up clears the watchdog register, leaving watchdog disabled.
// - Programmed watchdog overrides frequency test when square enable is clear.
// - Four-bit rate select sets square frequency: off, 32.768 kHz, 8.192 kHz..1 Hz.
// - Square enable bit gates the square wave onto the shared pin.
// - Century indicator inverts at century rollover only when toggle enable set.
// - With all functions off the pin follows the level bit.
// - Power-up clears enables and test, sets stop, halt and level bits.
// - Frequency test with oscillator running and others off toggles pin at 512 Hz.
// - Pin enable at D7 and square enable at D6 of alarm month register.
module rtc_alarm_watchdog_sqw (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    reset_in,
  // Oscillator pin
  input  wire logic                    osc_32k_in,
  // Register port from the serial engine
  input  wire logic                    wr_strobe_in,
  input  wire logic                    rd_strobe_in,
  input  wire logic [7:0]              addr_in,
  input  wire rtc_alarm_pkg::reg_byte_t wdata_in,
  input  wire logic [7:0]              addr_ptr_in,
  output logic      [7:0]              rdata_out,
  // Running time from the clock counters
  input  wire logic                    time_tick_in,
  input  wire logic [4:0]              month_in,
  input  wire logic [5:0]              date_in,
  input  wire logic [5:0]              hour_in,
  input  wire logic [6:0]              minute_in,
  input  wire logic [6:0]              second_in,
  input  wire logic                    century_roll_in,
  input  wire logic                    backup_mode_in,
  // Shared open-drain pin
  output logic                         shared_interrupt_pin_out,
  output logic                         shared_interrupt_pin_oe_n_out,
  // Status
  output logic                         alarm_match_flag_out,
  output logic                         watchdog_timeout_flag_out
);
  import rtc_alarm_pkg::*;

  // ==========================================================
  // Register state
  reg_byte_t   control_q;
  reg_byte_t   watchdog_q;
  reg_byte_t   alarm_month_q;
  reg_byte_t   alarm_date_q;
  reg_byte_t   alarm_hour_q;
  reg_byte_t   alarm_minute_q;
  reg_byte_t   alarm_second_q;
  reg_byte_t   square_rate_q;
  logic        osc_stop_q;
  logic        century_en_q;
  logic        century_q;

  wire logic   wr_wd   = wr_strobe_in && (addr_in == `OFS_WATCHDOG);
  wire logic   rd_flag = rd_strobe_in && (addr_in == `OFS_FLAGS);

  wire logic   alarm_pin_enable     = alarm_month_q[`BIT_PIN_ENABLE];
  wire logic   square_output_enable = alarm_month_q[`BIT_SQUARE_ENABLE];
  wire logic   backup_alarm_enable  = alarm_month_q[`BIT_BACKUP_ENABLE];
  wire logic   frequency_test       = control_q[`BIT_FREQ_TEST];
  wire logic   level_bit            = control_q[`BIT_LEVEL];
  wire logic [4:0] timeout_multiplier = watchdog_q[6:2];
  wire logic [1:0] timeout_resolution = watchdog_q[1:0];
  wire logic [3:0] square_rate_select = square_rate_q[7:4];

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      control_q     <= `RST_CONTROL;
      alarm_month_q <= `RST_ALARM_MONTH;
      alarm_hour_q  <= `RST_ALARM_HOUR;
      alarm_date_q   <= 8'h00;
      alarm_minute_q <= 8'h00;
      alarm_second_q <= 8'h00;
      square_rate_q <= `RST_SQUARE_RATE;
      osc_stop_q    <= 1'b1;
    end else if (wr_strobe_in) begin
      case (addr_in)
        `OFS_SECONDS:      osc_stop_q     <= wdata_in[`BIT_STOP];
        `OFS_CONTROL:      control_q      <= wdata_in;
        `OFS_ALARM_MONTH:  alarm_month_q  <= wdata_in;
        `OFS_ALARM_DATE:   alarm_date_q   <= wdata_in;
        `OFS_ALARM_HOUR:   alarm_hour_q   <= wdata_in;
        `OFS_ALARM_MINUTE: alarm_minute_q <= wdata_in;
        `OFS_ALARM_SECOND: alarm_second_q <= wdata_in;
        `OFS_SQUARE_RATE:  square_rate_q  <= {wdata_in[7:4], 4'h0};
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Century bit
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      century_en_q <= 1'b0;
      century_q    <= 1'b0;
    end else if (wr_strobe_in && addr_in == `OFS_CENTURY_HOURS) begin
      century_en_q <= wdata_in[`BIT_CENTURY_EN];
      century_q    <= wdata_in[`BIT_CENTURY];
    end else if (century_roll_in && century_en_q) begin
      century_q <= ~century_q;
    end
  end

  // ==========================================================
  // Oscillator synchroniser and divider
  logic        osc_s1_q;
  logic        osc_s2_q;
  logic        osc_s3_q;
  logic [14:0] div_q;
  wire logic   osc_tick = osc_s2_q && !osc_s3_q;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_32k_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  // A set stop bit freezes every divided rate; the 32.768 kHz square output still runs
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 15'h0000;
    end else if (osc_tick && !osc_stop_q) begin
      div_q <= div_q + 15'h0001;
    end
  end

  // Code 2 taps bit 1 (8.192 kHz), each step halves down to bit 14 (1 Hz)
  function automatic logic square_level(input logic [3:0] sel, input logic [14:0] div, input logic osc);
    logic [3:0] tap;
    tap = sel - 4'h1;
    if (sel == 4'h0) begin
      square_level = 1'b1;
    end else if (sel == 4'h1) begin
      square_level = osc;
    end else begin
      square_level = div[tap];
    end
  endfunction

  // ==========================================================
  // Alarm compare and flag
  repeat_mode_t mode;
  logic         match;
  logic         alarm_pend_q;
  logic         alarm_flag_q;
  logic         alarm_irq_q;
  wire logic [4:0] repeat_select = {alarm_date_q[`BIT_RPT5], alarm_date_q[`BIT_RPT_HI],
                                    alarm_hour_q[`BIT_RPT_HI], alarm_minute_q[`BIT_RPT_HI],
                                    alarm_second_q[`BIT_RPT_HI]};

  always_comb begin
    case (repeat_select)
      5'b1_1110: mode = RPT_MINUTE;
      5'b1_1100: mode = RPT_HOUR;
      5'b1_1000: mode = RPT_DAY;
      5'b1_0000: mode = RPT_MONTH;
      5'b0_0000: mode = RPT_YEAR;
      default:   mode = RPT_SECOND;
    endcase
  end

  wire logic m_sec = (second_in == alarm_second_q[6:0]);
  wire logic m_min = (minute_in == alarm_minute_q[6:0]);
  wire logic m_hr  = (hour_in   == alarm_hour_q[5:0]);
  wire logic m_dt  = (date_in   == alarm_date_q[5:0]);
  wire logic m_mo  = (month_in  == alarm_month_q[4:0]);

  always_comb begin
    case (mode)
      RPT_SECOND: match = 1'b1;
      RPT_MINUTE: match = m_sec;
      RPT_HOUR:   match = m_sec && m_min;
      RPT_DAY:    match = m_sec && m_min && m_hr;
      RPT_MONTH:  match = m_sec && m_min && m_hr && m_dt;
      RPT_YEAR:   match = m_sec && m_min && m_hr && m_dt && m_mo;
      default:    match = 1'b1;
    endcase
  end

  wire logic ptr_on_flags = (addr_ptr_in == `OFS_FLAGS);
  wire logic alarm_hit    = time_tick_in && match;
  wire logic alarm_fire   = (alarm_hit || alarm_pend_q) && !ptr_on_flags;
  wire logic alarm_irq_en = alarm_pin_enable && (!backup_mode_in || backup_alarm_enable);

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      alarm_pend_q <= 1'b0;
    end else if (alarm_hit && ptr_on_flags) begin
      alarm_pend_q <= 1'b1;
    end else if (alarm_fire) begin
      alarm_pend_q <= 1'b0;
    end
  end

  // Set wins over the read that clears
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      alarm_flag_q <= 1'b0;
      alarm_irq_q  <= 1'b0;
    end else begin
      if (alarm_fire) begin
        alarm_flag_q <= 1'b1;
      end else if (rd_flag) begin
        alarm_flag_q <= 1'b0;
      end
      if (alarm_fire && alarm_irq_en) begin
        alarm_irq_q <= 1'b1;
      end else if (rd_flag) begin
        alarm_irq_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Watchdog
  logic [10:0] wd_step_q;
  logic [10:0] wd_cnt_q;
  logic        wd_run_q;
  logic        wd_flag_q;
  logic        wd_irq_q;
  wire logic   wd_step = osc_tick && !osc_stop_q && (wd_step_q == 11'(`WD_STEP_TICKS - 1));

  // Timeout in sixteenths of a second
  function automatic logic [10:0] wd_limit(input logic [4:0] mult, input logic [1:0] res);
    logic [6:0] unit;
    case (res)
      2'b00:   unit = 7'd1;
      2'b01:   unit = 7'd4;
      2'b10:   unit = 7'd16;
      default: unit = 7'd64;
    endcase
    // Widen before multiplying: 31 times 64 does not fit the seven-bit unit
    wd_limit = 11'(mult) * 11'(unit);
  endfunction

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      watchdog_q <= `RST_WATCHDOG;
    end else if (wr_wd) begin
      watchdog_q <= {1'b0, wdata_in[6:0]};
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wd_step_q <= 11'h000;
      wd_cnt_q  <= 11'h000;
      wd_run_q  <= 1'b0;
    end else if (wr_wd) begin
      wd_step_q <= 11'h000;
      wd_cnt_q  <= 11'h000;
      wd_run_q  <= (wdata_in[6:2] != 5'h00);
    end else if (osc_tick && !osc_stop_q) begin
      wd_step_q <= wd_step ? 11'h000 : wd_step_q + 11'h001;
      if (wd_step && wd_run_q) begin
        if (wd_cnt_q + 11'h001 >= wd_limit(timeout_multiplier, timeout_resolution)) begin
          wd_cnt_q <= 11'h000;
          wd_run_q <= 1'b0;
        end else begin
          wd_cnt_q <= wd_cnt_q + 11'h001;
        end
      end
    end
  end

  wire logic wd_expire = wd_step && wd_run_q && osc_tick && !osc_stop_q &&
                         (wd_cnt_q + 11'h001 >= wd_limit(timeout_multiplier, timeout_resolution));

  // Expiry wins over a same-cycle clear
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wd_flag_q <= 1'b0;
      wd_irq_q  <= 1'b0;
    end else begin
      if (wd_expire) begin
        wd_flag_q <= 1'b1;
      end else if (rd_flag) begin
        wd_flag_q <= 1'b0;
      end
      if (wd_expire) begin
        wd_irq_q <= 1'b1;
      end else if (wr_wd && wdata_in == 8'h00) begin
        wd_irq_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Shared pin selection
  logic pin_low;
  wire logic wd_programmed = (watchdog_q != 8'h00);

  always_comb begin
    if (square_output_enable) begin
      pin_low = !square_level(square_rate_select, div_q, osc_s2_q);
    end else if ((alarm_irq_q && alarm_pin_enable) || wd_irq_q) begin
      pin_low = 1'b1;
    end else if (wd_programmed || alarm_pin_enable) begin
      pin_low = 1'b0;
    end else if (frequency_test) begin
      pin_low = !osc_stop_q && !div_q[`FT_DIV_BIT];
    end else begin
      pin_low = !level_bit;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shared_interrupt_pin_oe_n_out <= 1'b1;
      shared_interrupt_pin_out      <= 1'b0;
    end else begin
      shared_interrupt_pin_oe_n_out <= !pin_low;
      shared_interrupt_pin_out      <= 1'b0;
    end
  end

  // ==========================================================
  // Read data and status
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_strobe_in) begin
      case (addr_in)
        `OFS_SECONDS:       rdata_out <= {osc_stop_q, second_in};
        `OFS_CENTURY_HOURS: rdata_out <= {century_en_q, century_q, hour_in};
        `OFS_CONTROL:       rdata_out <= control_q;
        `OFS_WATCHDOG:      rdata_out <= watchdog_q;
        `OFS_ALARM_MONTH:   rdata_out <= alarm_month_q;
        `OFS_ALARM_DATE:    rdata_out <= alarm_date_q;
        `OFS_ALARM_HOUR:    rdata_out <= alarm_hour_q;
        `OFS_ALARM_MINUTE:  rdata_out <= alarm_minute_q;
        `OFS_ALARM_SECOND:  rdata_out <= alarm_second_q;
        `OFS_FLAGS:         rdata_out <= {wd_flag_q, alarm_flag_q, 6'h00};
        `OFS_SQUARE_RATE:   rdata_out <= square_rate_q;
        default:            rdata_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      alarm_match_flag_out      <= 1'b0;
      watchdog_timeout_flag_out <= 1'b0;
    end else begin
      alarm_match_flag_out      <= alarm_flag_q;
      watchdog_timeout_flag_out <= wd_flag_q;
    end
  end

endmodule
